/* rtl/bsl_boot_strap_latch.sv */
// Strap sampling, decode and override registers
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module bsl_boot_strap_latch (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic [4:0]            strap_pin_in,
    output logic      [4:0]            strap_pull_en,
    output logic      [4:0]            strap_pull_up,
    output logic                       strap_func_en,
    output bsl_pkg::bsl_config_s       cfg_out,
    input  wire logic [3:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata
);

    // ----------------------------------------------------------------
    // Pin synchroniser and capture
    // ----------------------------------------------------------------
    logic [4:0]           sync1_q;
    logic [4:0]           sync2_q;
    bsl_pkg::bsl_straps_s strap_q;
    bsl_pkg::bsl_straps_s strap_d;
    logic                 held_q;
    logic                 held_d;

    // Sync chain runs during reset too, so the pins are already
    // settled when the capture takes place at the first edge after
    // release; the chain flops themselves never reset to a port.
    always_ff @(posedge clk) begin
        sync1_q <= strap_pin_in;
        sync2_q <= sync1_q;
    end

    always_comb begin
        strap_d = strap_q;
        held_d  = held_q;
        if (!held_q) begin
            strap_d = bsl_pkg::bsl_straps_s'(sync2_q);
            held_d  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_q <= bsl_pkg::bsl_straps_s'(bsl_pkg::STRAP_PULL_DEFAULT);
            held_q  <= 1'b0;
        end else begin
            strap_q <= strap_d;
            held_q  <= held_d;
        end
    end

    // ----------------------------------------------------------------
    // Pad control
    // ----------------------------------------------------------------
    logic [4:0] pull_en_d;
    logic       func_en_d;

    always_comb begin
        pull_en_d = held_q ? 5'h00 : 5'h1f;
        func_en_d = held_q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_pull_en <= 5'h1f;
            strap_pull_up <= bsl_pkg::STRAP_PULL_DEFAULT;
            strap_func_en <= 1'b0;
        end else begin
            strap_pull_en <= pull_en_d;
            strap_pull_up <= bsl_pkg::STRAP_PULL_DEFAULT;
            strap_func_en <= func_en_d;
        end
    end

    // ----------------------------------------------------------------
    // Override control register
    // ----------------------------------------------------------------
    logic [5:0] ovr_q;
    logic [5:0] ovr_d;

    always_comb begin
        ovr_d = ovr_q;
        if (reg_wr && reg_addr == bsl_pkg::ADDR_OVERRIDE_CTL) begin
            ovr_d = reg_wdata[5:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovr_q <= bsl_pkg::OVR_RESET;
        end else begin
            ovr_q <= ovr_d;
        end
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    bsl_pkg::bsl_config_s cfg_d;

    always_comb begin
        cfg_d.ldo_sel_1v8 = strap_q.ldo_voltage_strap
                          ? bsl_pkg::LDO_SEL_1V8 : bsl_pkg::LDO_SEL_3V3;
        if (strap_q.boot_select_strap) begin
            cfg_d.boot_src = bsl_pkg::BOOT_SPI_FLASH;
        end else if (!strap_q.download_qualify_strap) begin
            cfg_d.boot_src = bsl_pkg::BOOT_DOWNLOAD;
        end else begin
            // Combination left open; flagged so boot ROM can halt
            cfg_d.boot_src = bsl_pkg::BOOT_UNDEFINED;
        end
        cfg_d.boot_log_en = strap_q.log_timing_strap;
        cfg_d.sdio_in_rise  = strap_q.log_timing_strap
                            ? bsl_pkg::EDGE_RISING : bsl_pkg::EDGE_FALLING;
        cfg_d.sdio_out_rise = strap_q.sdio_edge_strap
                            ? bsl_pkg::EDGE_RISING : bsl_pkg::EDGE_FALLING;
        if (ovr_q[bsl_pkg::OVR_VOLT_EN_BIT]) begin
            cfg_d.ldo_sel_1v8 = ovr_q[bsl_pkg::OVR_VOLT_VAL_BIT];
        end
        if (ovr_q[bsl_pkg::OVR_EDGE_EN_BIT]) begin
            cfg_d.sdio_in_rise  = ovr_q[bsl_pkg::OVR_IN_EDGE_BIT];
            cfg_d.sdio_out_rise = ovr_q[bsl_pkg::OVR_OUT_EDGE_BIT];
        end
        cfg_d.ldo_off = ovr_q[bsl_pkg::OVR_LDO_OFF_BIT];
    end

    // Decoded value lags the capture by one cycle; consumers must
    // wait for strap_func_en before trusting it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_out <= '0;
        end else begin
            cfg_out <= cfg_d;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                bsl_pkg::ADDR_STRAP_STATUS: begin
                    rdata_d = {27'h0000000, strap_q};
                end
                bsl_pkg::ADDR_DECODE_STAT: begin
                    rdata_d = {25'h0000000, cfg_out};
                end
                bsl_pkg::ADDR_OVERRIDE_CTL: begin
                    rdata_d = {26'h0000000, ovr_q};
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

endmodule

/* rtl/bsl_pkg.sv */
// Package of constants and types for the boot strap latch
package bsl_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_STRAP_STATUS = 4'h0;
    localparam logic [3:0] ADDR_DECODE_STAT  = 4'h4;
    localparam logic [3:0] ADDR_OVERRIDE_CTL = 4'h8;

    // ----------------------------------------------------------------
    // Strap status field positions
    // ----------------------------------------------------------------
    localparam int STRAP_VOLT_BIT = 0;
    localparam int STRAP_BOOT_BIT = 1;
    localparam int STRAP_DLQ_BIT  = 2;
    localparam int STRAP_LOG_BIT  = 3;
    localparam int STRAP_SDIO_BIT = 4;
    localparam int STRAP_COUNT    = 5;

    // ----------------------------------------------------------------
    // Override control field positions and reset value
    // ----------------------------------------------------------------
    localparam int OVR_VOLT_EN_BIT  = 0;
    localparam int OVR_VOLT_VAL_BIT = 1;
    localparam int OVR_EDGE_EN_BIT  = 2;
    localparam int OVR_IN_EDGE_BIT  = 3;
    localparam int OVR_OUT_EDGE_BIT = 4;
    localparam int OVR_LDO_OFF_BIT  = 5;
    localparam logic [5:0] OVR_RESET = 6'h00;

    // Internal weak defaults while reset is held (1 = pull-up)
    localparam logic [4:0] STRAP_PULL_DEFAULT = 5'h1a;

    // Boot source encodings
    localparam logic [1:0] BOOT_SPI_FLASH = 2'h1;
    localparam logic [1:0] BOOT_DOWNLOAD  = 2'h2;
    localparam logic [1:0] BOOT_UNDEFINED = 2'h0;

    // Edge encodings: 0 = falling, 1 = rising
    localparam logic EDGE_FALLING = 1'b0;
    localparam logic EDGE_RISING  = 1'b1;

    // Regulator voltage select: 0 = always-on level, 1 = 1.8 V
    localparam logic LDO_SEL_3V3 = 1'b0;
    localparam logic LDO_SEL_1V8 = 1'b1;

    typedef struct packed {
        logic sdio_edge_strap;
        logic log_timing_strap;
        logic download_qualify_strap;
        logic boot_select_strap;
        logic ldo_voltage_strap;
    } bsl_straps_s;

    typedef struct packed {
        logic       ldo_off;
        logic       ldo_sel_1v8;
        logic [1:0] boot_src;
        logic       boot_log_en;
        logic       sdio_in_rise;
        logic       sdio_out_rise;
    } bsl_config_s;

endpackage

/* verif/bsl_assertions.sv */
// Port checker for the boot strap latch
`timescale 1ns/10ps
module bsl_assertions (
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic [4:0]           strap_pull_en,
    input wire logic [4:0]           strap_pull_up,
    input wire logic                 strap_func_en,
    input wire bsl_pkg::bsl_config_s cfg_out,
    input wire logic [3:0]           reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_ovr_wr;
        reg_wr && reg_addr == bsl_pkg::ADDR_OVERRIDE_CTL;
    endsequence
    sequence s_edge_wr;
        s_ovr_wr ##0 reg_wdata[2];
    endsequence
    a_pull_kind: assert property (strap_pull_up == 5'h1a)
        else $error("pull direction wrong");
    a_pins_freed: assert property ($rose(strap_func_en) |-> !strap_pull_en)
        else $error("pulls left on after release");
    a_func_holds: assert property (strap_func_en |=> strap_func_en)
        else $error("release dropped");
    a_cfg_held: assert property (strap_func_en |=>
        $stable(cfg_out.boot_src) && $stable(cfg_out.boot_log_en))
        else $error("boot decode changed");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    // Control register lands at the write edge, cfg_out one edge later
    a_ldo_off: assert property (s_ovr_wr |-> ##2
        cfg_out.ldo_off == $past(reg_wdata[5], 2))
        else $error("regulator off not applied");
    a_volt_ovr: assert property (s_ovr_wr ##0 reg_wdata[0] |-> ##2
        cfg_out.ldo_sel_1v8 == $past(reg_wdata[1], 2))
        else $error("voltage override not applied");
    a_edge_ovr: assert property (s_edge_wr |-> ##2
        cfg_out.sdio_in_rise == $past(reg_wdata[3], 2) &&
        cfg_out.sdio_out_rise == $past(reg_wdata[4], 2))
        else $error("edge override not applied");
endmodule
bind bsl_boot_strap_latch bsl_assertions u_bsl_assertions (
    .clk(clk), .resetn(resetn), .strap_pull_en(strap_pull_en),
    .strap_pull_up(strap_pull_up), .strap_func_en(strap_func_en),
    .cfg_out(cfg_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

/* verif/bsl_board.sv */
// Board model: strap drivers, weak pulls and floating pins
`timescale 1ns/10ps
module bsl_board (
    input  wire logic [4:0] drv_val,
    input  wire logic [4:0] drv_en,
    input  wire logic [4:0] pull_en,
    input  wire logic [4:0] pull_up,
    input  wire logic       clk,
    output logic      [4:0] pin
);
    logic [4:0] last_q;
    // board drive wins over the weak pulls
    // A floating unpulled pin flips each cycle so no stale level passes
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin[i] = drv_en[i] ? drv_val[i] :
                     pull_en[i] ? pull_up[i] : ~last_q[i];
        end
    end
    always_ff @(posedge clk) begin
        last_q <= pin;
    end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the boot strap latch
`timescale 1ns/10ps
module tb_top;
    logic                 clk = 1'b0;
    logic                 resetn = 1'b0;
    logic [4:0]           pins;
    logic [4:0]           drv_val = 5'h00;
    logic [4:0]           drv_en = 5'h00;
    logic [4:0]           pull_en;
    logic [4:0]           pull_up;
    logic                 func_en;
    bsl_pkg::bsl_config_s cfg;
    logic [3:0]           addr = 4'h0;
    logic [31:0]          wdata = 32'h0;
    logic                 wr = 1'b0;
    logic                 rd = 1'b0;
    logic [31:0]          rdata;
    logic [31:0]          d;
    int                   n_errors = 0;
    int                   checks_done = 0;
    always #12.5 clk = ~clk;
    bsl_boot_strap_latch u_bsl_boot_strap_latch (.clk(clk),
        .resetn(resetn), .strap_pin_in(pins), .strap_pull_en(pull_en),
        .strap_pull_up(pull_up), .strap_func_en(func_en), .cfg_out(cfg),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata));
    bsl_board u_bsl_board (.drv_val(drv_val), .drv_en(drv_en),
        .pull_en(pull_en), .pull_up(pull_up), .clk(clk), .pin(pins));
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd_reg(logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wr_reg(logic [3:0] a, logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Board-side minimum low time, shortened to keep runs brief
    task automatic boot(logic [4:0] v, logic [4:0] en);
        @(posedge clk);
        resetn <= 1'b0;
        drv_val <= v;
        drv_en <= en;
        repeat (5) @(posedge clk);
        chk("pull_en_rst", {27'h0, pull_en}, 32'h1f);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [31:0] exp_cfg(logic [4:0] s, logic [5:0] o);
        logic [1:0] b;
        b = s[1] ? 2'h1 : (s[2] ? 2'h0 : 2'h2);
        return {25'h0, o[5], o[0] ? o[1] : s[0], b, s[3],
                o[2] ? o[3] : s[3], o[2] ? o[4] : s[4]};
    endfunction
    // undriven pins take the weak defaults
    task automatic t_pulls;
        boot(5'h00, 5'h00);
        chk("func_en", {31'h0, func_en}, 32'h1);
        chk("pull_en", {27'h0, pull_en}, 32'h0);
        rd_reg(4'h0);
        chk("default", d, 32'h1a);
    endtask
    // every pattern captured, decoded and held
    task automatic t_capture;
        for (int v = 0; v < 32; v++) begin
            // Odd patterns strap the regulator to 1.8 V
            boot(v[4:0], 5'h1f);
            rd_reg(4'h0);
            chk("status", d, {27'h0, v[4:0]});
            rd_reg(4'h4);
            chk("decode", d, exp_cfg(v[4:0], 6'h00));
            @(posedge clk);
            drv_val <= ~v[4:0];
            repeat (4) @(posedge clk);
            rd_reg(4'h0);
            chk("held", d, {27'h0, v[4:0]});
        end
    endtask
    task automatic t_override;
        boot(5'h00, 5'h1f);
        rd_reg(4'h8);
        chk("ovr_reset", d, 32'h0);
        wr_reg(4'h8, 32'h3f);
        rd_reg(4'h4);
        chk("ovr_on", d, exp_cfg(5'h00, 6'h3f));
        wr_reg(4'h8, 32'h02);
        rd_reg(4'h4);
        chk("ovr_off", d, exp_cfg(5'h00, 6'h02));
        rd_reg(4'h8);
        chk("ovr_rw", d, 32'h02);
        wr_reg(4'h0, 32'h1f);
        rd_reg(4'h0);
        chk("ro", d, 32'h0);
        rd_reg(4'hc);
        chk("unmapped", d, 32'h0);
    endtask
    task automatic complete_run;
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        t_pulls;
        t_capture;
        t_override;
        complete_run;
    end
    initial begin
        #100000;
        n_errors++;
        complete_run;
    end
endmodule
